/* File: common/scl_pkg.sv */
`default_nettype none
package scl_pkg;
    // Scheme select encodings
    localparam logic [1:0] SCL_SCHEME_ACTIVE  = 2'h0;
    localparam logic [1:0] SCL_SCHEME_PASSIVE = 2'h1;
    // Clock and timing
    localparam int SCL_REF_CLK_MHZ       = 100;
    localparam int SCL_SERIAL_MAX_PERIOD_NS = 71;
    localparam int SCL_REF_PERIOD_NS     = 1000 / SCL_REF_CLK_MHZ;
    // Longest period rounds down; half period per clock phase
    localparam int SCL_SERIAL_DIV        = SCL_SERIAL_MAX_PERIOD_NS / SCL_REF_PERIOD_NS;
    localparam int SCL_HALF_DIV          = (SCL_SERIAL_DIV / 2 < 1) ? 1 : SCL_SERIAL_DIV / 2;
    localparam int SCL_INIT_CYCLES       = 136;
    // Image length in bits (plain default, counter width)
    localparam int SCL_CNT_W             = 24;
    localparam logic [23:0] SCL_IMAGE_BITS_DEFAULT = 24'h000100;
    // Flash read command and address
    localparam logic [7:0] SCL_FLASH_READ_CMD = 8'h03;
    localparam int SCL_CMD_BITS          = 32;
    localparam logic [23:0] SCL_FIRST_IMAGE_ADDR = 24'h000000;
endpackage
`default_nettype wire

/* File: rtl/scl_loader.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Two-image mode: master loads itself first, then streams second image to all slaves.
// R2 - Scheme select 00 is active master; 01 is passive slave.
// R3 - Master keeps chain enable output high while loading its own image.
// R4 - After own load, master drives chain enable output low and keeps clocking; code stops the clock in single-image mode.
// R5 - Single-image mode: all devices take one stream together in one cycle.
// R6 - Compressed and uncompressed images are both accepted.
// R7 - Active serial clock is at least 14 MHz, one bit per period.
// R8 - Only one flash per arrangement; flashes are never chained.
// R9 - While chain enable input is high, flash interface is not driven.
// R10 - Stay reset while request is low; resume when request released.
// R11 - Passive mode samples data on each rising edge of host clock.
// R12 - Complete is low while loading, high after success, low on new request.
// R13 - User I/O tri-stated until initialization finishes.
// R14 - Init complete is high during request low and first 136 cycles.
// R15 - Host holds passive clock steady in user mode; active clock is output.
// R16 - Host holds serial data at a defined level in user mode.
// R17 - Active mode launches commands and captures data on falling clock edge.
// R18 - After own data is captured, chain enable output goes low.
// R19 - After complete goes high, 136 init cycles precede user mode.
// R20 - Received bits are counted against the image length to end loading.
// R21 - While chain enable input is high, serial activity is ignored.
module scl_loader
    import scl_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Configuration straps and control pins
    input  wire logic [1:0]  scheme_select,
    input  wire logic        config_request_n,
    input  wire logic        chain_enable_in_n,
    input  wire logic        init_done_enable,
    input  wire logic        two_image_mode,
    input  wire logic [23:0] image_bits,
    // Shared serial link
    input  wire logic        config_serial_clock_in,
    output logic             config_serial_clock_out,
    output logic             config_serial_clock_oe,
    input  wire logic        config_serial_data_in,
    // Flash side
    output logic             flash_select_n,
    output logic             flash_select_oe,
    output logic             flash_command_line,
    output logic             flash_command_oe,
    // Chain and status
    output logic             chain_enable_out_n,
    input  wire logic        config_complete_in,
    output logic             config_complete_out,
    output logic             config_complete_oe,
    output logic             config_status_n,
    output logic             init_complete,
    output logic             user_mode,
    output logic             user_io_oe,
    // Received stream
    output logic             cfg_bit_valid,
    output logic             cfg_bit
);

    typedef enum logic [5:0] {
        SCL_IDLE    = 6'h01,
        SCL_COMMAND = 6'h02,
        SCL_LOAD    = 6'h04,
        SCL_FORWARD = 6'h08,
        SCL_WAITCD  = 6'h10,
        SCL_INIT    = 6'h20
    } scl_state_e;

    scl_state_e        state_reg;
    logic [1:0]        req_sync_reg;
    logic [1:0]        ce_sync_reg;
    logic [2:0]        clk_sync_reg;
    logic [1:0]        dat_sync_reg;
    logic [1:0]        cd_sync_reg;
    logic [1:0]        sel_sync0_reg;
    logic [1:0]        sel_sync1_reg;
    logic [7:0]        div_reg;
    logic              sclk_reg;
    logic [SCL_CNT_W-1:0] bit_cnt_reg;
    logic [5:0]        cmd_cnt_reg;
    logic [31:0]       cmd_shift_reg;
    logic [7:0]        init_cnt_reg;
    logic              init_seen_reg;
    logic              own_done_reg;

    logic              req_n;
    logic              chain_hold;
    logic              active_mode;
    logic              passive_mode;
    logic              rise_ext;
    logic              half_tick;
    logic              fall_int;
    logic              sample_bit;
    logic              last_bit;

    // Pin synchronisers; the second stage is the only reader of the first
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            req_sync_reg  <= 2'h0;
            ce_sync_reg   <= 2'h3;
            clk_sync_reg  <= 3'h0;
            dat_sync_reg  <= 2'h0;
            cd_sync_reg   <= 2'h0;
            sel_sync0_reg <= 2'h0;
            sel_sync1_reg <= 2'h0;
        end
        else
        begin
            req_sync_reg  <= {req_sync_reg[0], config_request_n};
            ce_sync_reg   <= {ce_sync_reg[0], chain_enable_in_n};
            clk_sync_reg  <= {clk_sync_reg[1:0], config_serial_clock_in};
            dat_sync_reg  <= {dat_sync_reg[0], config_serial_data_in};
            cd_sync_reg   <= {cd_sync_reg[0], config_complete_in};
            sel_sync0_reg <= scheme_select;
            sel_sync1_reg <= sel_sync0_reg;
        end
    end

    assign req_n        = req_sync_reg[1];
    assign chain_hold   = ce_sync_reg[1];                          // R9
    assign active_mode  = (sel_sync1_reg == SCL_SCHEME_ACTIVE);    // R2
    assign passive_mode = (sel_sync1_reg == SCL_SCHEME_PASSIVE);   // R2
    assign rise_ext     = clk_sync_reg[1] & ~clk_sync_reg[2];      // R11

    // Serial clock divider: three cycles a half gives 60 ns, above the 14 MHz floor
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_reg  <= 8'h00;
            sclk_reg <= 1'b0;
        end
        else if (state_reg == SCL_COMMAND || state_reg == SCL_LOAD || state_reg == SCL_FORWARD)
        begin
            if (half_tick)
            begin
                div_reg  <= 8'h00;
                sclk_reg <= ~sclk_reg;                             // R7
            end
            else
            begin
                div_reg <= div_reg + 8'h01;
            end
        end
        else
        begin
            div_reg  <= 8'h00;
            sclk_reg <= 1'b0;
        end
    end

    assign half_tick = (div_reg == 8'(SCL_HALF_DIV - 1));
    // Falling edge of the generated clock: launch and capture point
    assign fall_int  = half_tick & sclk_reg;                       // R17

    // One bit per clock period; passive side takes host rising edges
    // Hold-off gates both schemes, so no strobe leaks out in the cycle an active load aborts
    assign sample_bit = !chain_hold
                        && (active_mode ? (fall_int && (state_reg == SCL_LOAD || state_reg == SCL_FORWARD))
                                        : (rise_ext && state_reg == SCL_LOAD)); // R11 R21
    assign last_bit   = (bit_cnt_reg == image_bits - 24'h000001); // R20

    // Loading sequence
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg     <= SCL_IDLE;
            bit_cnt_reg   <= '0;
            cmd_cnt_reg   <= 6'h00;
            cmd_shift_reg <= 32'h0;
            own_done_reg  <= 1'b0;
        end
        else if (!req_n)
        begin
            state_reg    <= SCL_IDLE;                              // R10
            bit_cnt_reg  <= '0;
            own_done_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                SCL_IDLE:
                begin
                    if (active_mode && !chain_hold)
                    begin
                        state_reg     <= SCL_COMMAND;
                        cmd_cnt_reg   <= 6'h00;
                        cmd_shift_reg <= {SCL_FLASH_READ_CMD, SCL_FIRST_IMAGE_ADDR};
                    end
                    else if (passive_mode && !chain_hold)
                    begin
                        state_reg <= SCL_LOAD;                      // R5
                    end
                end
                SCL_COMMAND:
                begin
                    if (chain_hold)
                        state_reg <= SCL_IDLE;                      // R9
                    else if (fall_int)
                    begin
                        cmd_shift_reg <= {cmd_shift_reg[30:0], 1'b0}; // R17
                        cmd_cnt_reg   <= cmd_cnt_reg + 6'h01;
                        if (cmd_cnt_reg == 6'(SCL_CMD_BITS - 1))
                            state_reg <= SCL_LOAD;
                    end
                end
                SCL_LOAD:
                begin
                    if (active_mode && chain_hold)
                        state_reg <= SCL_IDLE;                      // R9
                    else if (sample_bit)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 24'h000001;    // R20
                        if (last_bit)
                        begin
                            bit_cnt_reg  <= '0;
                            own_done_reg <= 1'b1;                   // R18
                            state_reg    <= (active_mode && two_image_mode) ? SCL_FORWARD : SCL_WAITCD; // R1
                        end
                    end
                end
                SCL_FORWARD:
                begin
                    if (chain_hold)
                        state_reg <= SCL_IDLE;                      // R9
                    else if (sample_bit)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 24'h000001;    // R4
                        if (last_bit)
                            state_reg <= SCL_WAITCD;
                    end
                end
                SCL_WAITCD:
                begin
                    if (cd_sync_reg[1])
                        state_reg <= SCL_INIT;                      // R19
                end
                SCL_INIT:
                begin
                    state_reg <= SCL_INIT;
                end
            endcase
        end
    end

    // Initialization count; image data is passed on raw, compressed or not
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            init_cnt_reg  <= 8'h00;
            init_seen_reg <= 1'b0;
        end
        else if (!req_n)
        begin
            init_cnt_reg  <= 8'h00;
            init_seen_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == SCL_INIT && init_cnt_reg != 8'(SCL_INIT_CYCLES))
                init_cnt_reg <= init_cnt_reg + 8'h01;               // R19
            if (sample_bit && bit_cnt_reg == 24'(SCL_INIT_CYCLES - 1))
                init_seen_reg <= 1'b1;                              // R14
        end
    end

    // Registered data outputs
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_bit_valid       <= 1'b0;
            cfg_bit             <= 1'b0;
            chain_enable_out_n  <= 1'b1;
            config_complete_out <= 1'b0;
            config_status_n     <= 1'b0;
            init_complete       <= 1'b1;
            user_mode           <= 1'b0;
        end
        else
        begin
            cfg_bit_valid       <= sample_bit && state_reg == SCL_LOAD; // R6
            cfg_bit             <= dat_sync_reg[1];                 // R17
            chain_enable_out_n  <= ~(own_done_reg & req_n);         // R3 R4 R18
            config_complete_out <= 1'b0;                            // R12
            config_status_n     <= req_n;
            user_mode           <= req_n && state_reg == SCL_INIT
                                   && init_cnt_reg == 8'(SCL_INIT_CYCLES); // R13
            if (!init_done_enable || !req_n || state_reg == SCL_IDLE || !init_seen_reg)
                init_complete <= 1'b1;                              // R14
            else
                init_complete <= (state_reg == SCL_INIT && init_cnt_reg == 8'(SCL_INIT_CYCLES));
        end
    end

    // Complete line is open drain: pulled low until own data is in
    assign config_complete_oe = ~own_done_reg | ~req_n;             // R12

    // Flash and clock pins released whenever the chain input is high
    assign config_serial_clock_out = sclk_reg;
    assign config_serial_clock_oe  = active_mode && !chain_hold && state_reg != SCL_WAITCD
                                     && state_reg != SCL_INIT && req_n; // R9 R15
    assign flash_select_n     = ~(state_reg == SCL_COMMAND || state_reg == SCL_LOAD || state_reg == SCL_FORWARD);
    assign flash_select_oe    = active_mode && !chain_hold;        // R9
    assign flash_command_line = cmd_shift_reg[31];
    assign flash_command_oe   = active_mode && !chain_hold;        // R9
    assign user_io_oe         = user_mode & req_n;                  // R13

endmodule
`default_nettype wire

/* File: tb/scl_loader_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scl_loader_sva
    import scl_pkg::*;
(
    // Clock, reset and controls
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [1:0] scheme_select,
    input wire logic       config_request_n,
    input wire logic       chain_enable_in_n,
    input wire logic       config_complete_in,
    // Observed outputs
    input wire logic       config_serial_clock_out,
    input wire logic       config_serial_clock_oe,
    input wire logic       flash_select_n,
    input wire logic       flash_select_oe,
    input wire logic       flash_command_oe,
    input wire logic       chain_enable_out_n,
    input wire logic       config_complete_oe,
    input wire logic       config_status_n,
    input wire logic       init_complete,
    input wire logic       user_mode,
    input wire logic       user_io_oe,
    input wire logic       cfg_bit_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Cycles the complete line has stayed high; saturates so it never wraps
    logic [8:0] done_cnt_reg;
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
            done_cnt_reg <= 9'h000;
        else if (!config_complete_in)
            done_cnt_reg <= 9'h000;
        else if (done_cnt_reg != 9'h1ff)
            done_cnt_reg <= done_cnt_reg + 9'h001;
    // Four cycles cover the two-stage input synchronisers
    sequence s_holdoff;
        chain_enable_in_n [*4];
    endsequence
    sequence s_req_held;
        !config_request_n [*4];
    endsequence
    a_holdoff_quiet:
    assert property (s_holdoff |-> !flash_select_oe && !flash_command_oe && !config_serial_clock_oe && !cfg_bit_valid)
        else $error("flash interface active during hold-off");
    a_request_reset:
    assert property (s_req_held |-> !config_status_n && !user_mode && init_complete && config_complete_oe)
        else $error("request low did not hold the loader in reset");
    a_own_bits_chain:
    assert property (cfg_bit_valid |-> chain_enable_out_n)
        else $error("own bit taken after chain enable went low");
    a_chain_after_load:
    assert property ($fell(config_complete_oe) |-> ##[0:2] !chain_enable_out_n)
        else $error("complete released without chain enable low");
    a_user_after_init:
    assert property ($rose(user_mode) |-> done_cnt_reg >= 9'h088)
        else $error("user mode before the init cycles ran");
    a_user_io_late:
    assert property (user_io_oe |-> user_mode && config_complete_in)
        else $error("user pins enabled before initialisation ended");
    a_serial_rate:
    assert property (config_serial_clock_oe && !flash_select_n && $changed(config_serial_clock_out)
        |-> ##[1:4] ($changed(config_serial_clock_out) || flash_select_n))
        else $error("serial clock half period too long");
    a_passive_slave:
    assert property ((scheme_select == SCL_SCHEME_PASSIVE) [*4] |-> !config_serial_clock_oe && !flash_select_oe)
        else $error("passive slave drives clock or flash select");
    a_bit_pulse:
    assert property (cfg_bit_valid |=> !cfg_bit_valid)
        else $error("bit strobe longer than one cycle");
endmodule
bind scl_loader scl_loader_sva u_sva (.ref_clk, .resetn, .scheme_select, .config_request_n, .chain_enable_in_n,
    .config_complete_in, .config_serial_clock_out, .config_serial_clock_oe, .flash_select_n, .flash_select_oe,
    .flash_command_oe, .chain_enable_out_n, .config_complete_oe, .config_status_n, .init_complete, .user_mode,
    .user_io_oe, .cfg_bit_valid);
`default_nettype wire

/* File: tb/scl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// The single flash on the interface; nothing is chained behind it
module scl_flash_model
(
    // Board lines
    input wire logic        sclk,
    input wire logic        select_n,
    input wire logic        command,
    // Image content, repeating every 16 bits
    input wire logic [15:0] pattern,
    output logic            dout
);
    int unsigned n_rise = 0;
    logic [7:0]  cmd_reg;
    initial dout = 1'b1;
    // Command latched on rising edges; deselect restarts the frame
    always @(posedge sclk or posedge select_n)
        if (select_n)
            n_rise <= 0;
        else
        begin
            if (n_rise < 8)
                cmd_reg <= {cmd_reg[6:0], command};
            n_rise <= n_rise + 1;
        end
    // Data launched on falling edges; released line floats to its pull-up
    always @(negedge sclk or posedge select_n)
        if (select_n)
            dout <= 1'b1;
        else if (n_rise >= 32)
            dout <= pattern[(n_rise - 32) % 16];
endmodule
`default_nettype wire

/* File: tb/scl_loader_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module scl_loader_tb;
    import scl_pkg::*;
    logic        ref_clk, resetn, config_request_n, chain_enable_in_n, init_done_enable, two_image_mode;
    logic [1:0]  scheme_select;
    logic [23:0] image_bits;
    logic [15:0] pattern;
    logic        host_clk, host_data, config_serial_clock_in, config_serial_data_in, flash_dout, sel_line;
    logic        config_serial_clock_out, config_serial_clock_oe, flash_select_n, flash_select_oe;
    logic        flash_command_line, flash_command_oe, chain_enable_out_n, config_complete_in;
    logic        config_complete_out, config_complete_oe, config_status_n, init_complete;
    logic        user_mode, user_io_oe, cfg_bit_valid, cfg_bit;
    int          n_errors = 0;
    int          checks = 0;
    int          rises_seen = 0;
    integer      seed = 32;
    logic        got[$];
    // Board lines: pull-ups win wherever nobody drives
    assign sel_line = flash_select_oe ? flash_select_n : 1'b1;
    assign config_serial_clock_in = config_serial_clock_oe ? config_serial_clock_out
        : (scheme_select == SCL_SCHEME_PASSIVE ? host_clk : 1'b1);
    assign config_serial_data_in = (scheme_select == SCL_SCHEME_PASSIVE) ? host_data : flash_dout;
    assign config_complete_in = config_complete_oe ? config_complete_out : 1'b1;
    scl_loader dut (.ref_clk, .resetn, .scheme_select, .config_request_n, .chain_enable_in_n, .init_done_enable,
        .two_image_mode, .image_bits, .config_serial_clock_in, .config_serial_clock_out, .config_serial_clock_oe,
        .config_serial_data_in, .flash_select_n, .flash_select_oe, .flash_command_line, .flash_command_oe,
        .chain_enable_out_n, .config_complete_in, .config_complete_out, .config_complete_oe, .config_status_n,
        .init_complete, .user_mode, .user_io_oe, .cfg_bit_valid, .cfg_bit);
    scl_flash_model fl (.sclk(config_serial_clock_in), .select_n(sel_line), .command(flash_command_line),
        .pattern(pattern), .dout(flash_dout));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Flash clock rises counted in the last selected cycle of each frame
    always @(posedge ref_clk)
        if (sel_line === 1'b0)
            rises_seen <= fl.n_rise;
    // Record every bit the loader reports as taken
    always @(posedge ref_clk)
        if (cfg_bit_valid === 1'b1)
            got.push_back(cfg_bit);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hold the request low with new straps, check the reset state, release
    task automatic restart(input logic [1:0] scheme, input logic two);
        @(posedge ref_clk);
        #1;
        config_request_n = 1'b0;
        scheme_select = scheme;
        two_image_mode = two;
        init_done_enable = 1'($random(seed));
        image_bits = 24'h000080 + 24'($random(seed) & 31);
        pattern = 16'($random(seed));
        repeat (6) @(posedge ref_clk);
        #1;
        check("complete_line", config_complete_in, 1'b0);
        check("init_complete", init_complete, 1'b1);
        check("user_io_oe", user_io_oe, 1'b0);
        got.delete();
        config_request_n = 1'b1;
    endtask
    // Wait for the own image to end, compare every bit, then wait for user mode
    task automatic finish_load(input string name);
        for (int i = 0; i < 20000 && chain_enable_out_n !== 1'b0; i++)
            @(posedge ref_clk);
        #1;
        check("bit_count", got.size(), image_bits);
        check("init_mid", init_complete, !(init_done_enable && image_bits >= 24'(SCL_INIT_CYCLES)));
        foreach (got[j])
            check("cfg_bit", got[j], pattern[j % 16]);
        for (int i = 0; i < 20000 && user_mode !== 1'b1; i++)
            @(posedge ref_clk);
        #1;
        check("user_io_oe", user_io_oe, 1'b1);
        check("complete_line", config_complete_in, 1'b1);
        check("init_end", init_complete, 1'b1);
        if (scheme_select == SCL_SCHEME_ACTIVE)
            check("flash_rises", rises_seen, SCL_CMD_BITS + image_bits * (two_image_mode ? 2 : 1));
        $display("test %s done", name);
    endtask
    task automatic run(input logic [1:0] scheme, input logic two, input string name);
        restart(scheme, two);
        if (scheme == SCL_SCHEME_PASSIVE)
            for (int k = 0; k < image_bits; k++)
            begin
                host_data = pattern[k % 16];
                #62 host_clk = 1'b1;
                #63 host_clk = 1'b0;
            end
        if (scheme == SCL_SCHEME_ACTIVE)
        begin
            for (int i = 0; i < 20000 && chain_enable_out_n !== 1'b0; i++)
                @(posedge ref_clk);
            #1;
            check("read_cmd", fl.cmd_reg, SCL_FLASH_READ_CMD);
            check("fwd_clock", config_serial_clock_oe, two);
        end
        finish_load(name);
    endtask
    initial
    begin
        resetn = 1'b0;
        scheme_select = SCL_SCHEME_ACTIVE;
        config_request_n = 1'b0;
        chain_enable_in_n = 1'b1;
        init_done_enable = 1'b1;
        two_image_mode = 1'b0;
        image_bits = 24'h000010;
        pattern = 16'h0000;
        host_clk = 1'b0;
        host_data = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        // Programmer holds the interface off, then lets go
        restart(SCL_SCHEME_ACTIVE, 1'b0);
        repeat (300) @(posedge ref_clk);
        check("holdoff_bits", got.size(), 0);
        check("holdoff_select", flash_select_oe, 1'b0);
        #1 chain_enable_in_n = 1'b0;
        finish_load("holdoff");
        run(SCL_SCHEME_ACTIVE, 1'b1, "two_image");
        run(SCL_SCHEME_PASSIVE, 1'b0, "passive");
        // A request while the read command is still going out must start the image over
        restart(SCL_SCHEME_ACTIVE, 1'b0);
        repeat (150) @(posedge ref_clk);
        run(SCL_SCHEME_ACTIVE, 1'b0, "abort");
        for (int r = 0; r < 4; r++)
            run(2'($random(seed) & 1), 1'($random(seed)), "random");
        final_report;
    end
    // Whole run needs about fifteen thousand cycles; this is a generous ceiling
    initial
    begin
        #600000;
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire
